// ---- rtl/dac_ctrl_pkg.sv ----
// Shared constants and types of the serial converter control logic
package dac_ctrl_pkg;

   // Command word layout
   localparam int WORD_W      = 16;
   localparam int DATA_W      = 12;
   localparam int DATA_LSB    = 0;
   localparam int MODE_LSB    = 12;
   localparam int MODE_MSB    = 13;
   localparam int MODE_W      = 2;
   localparam int WORD_MSB    = 15;

   // Reset values
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] CODE_ZERO  = 12'h000;

   // Buffer shape
   localparam int FIFO_DEPTH  = 4;

   // Pin sampling
   localparam int SYNC_STAGES = 2;

   // Converter operating mode, in field order 00..11
   typedef enum logic [1:0] {
      mode_normal,
      mode_pd_1k,
      mode_pd_100k,
      mode_pd_hiz
   } mode_t;

endpackage

// ---- rtl/serial_dac_control_interface.sv ----
// Serial converter control logic with its word buffer
//
// What this block does
// - Power-on reset clears or presets every register except the buffer storage, and forces zero-scale output.
// - Output stays zero-scale until a complete frame has been latched.
// - Clear pin low forces zero-scale output immediately, without a clock.
// - Clear resets the shift, chain, capture, buffer and converter registers; pin samplers keep running.
// - After clear releases, the next frame-select rise updates the output.
// - A 16-bit shift register receives each serial word.
// - Word is four control bits then twelve data bits.
// - Bits arrive MSB first; the two leading bits are ignored.
// - Data bits are straight unsigned binary, zero to full scale minus one.
// - Bits 13:12 select normal, 1k, 100k or open power-down.
// - Power-down ties output to ground via chosen resistor, or leaves it open.
// - Power-down selection travels in the data word on the normal path.
// - Data of words written while powered down is kept; the word that restores normal mode loads its own data.
// - Serial data is taken only while frame-select is low.
// - Every falling shift-clock edge in a frame shifts, even beyond sixteen.
// - Frame-select rise latches the last sixteen shifted bits and updates output.
// - Chain output is high impedance while frame-select is high.
// - In a frame, chain output is the shift register end, fifteen edges late.

// Word buffer between frame capture and converter register
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic             push;
   logic             pop;

   // Honest full and empty from the fill count
   assign in_ready  = (count != CNT_W'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // Storage writes
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + CNT_W'(push) - CNT_W'(pop);
      end
   end
endmodule

// Converter control: serial capture, chain output, mode and code
module serial_dac_control_interface #(
   parameter int WORD_BITS = dac_ctrl_pkg::WORD_W,
   parameter int BUF_DEPTH = dac_ctrl_pkg::FIFO_DEPTH
) (
   input  wire logic                                clk,
   input  wire logic                                reset,
   input  wire logic                                frame_select_n,
   input  wire logic                                shift_clock,
   input  wire logic                                serial_input_line,
   input  wire logic                                async_zero_clear_n,
   output logic                                     chain_output_line,
   output logic                                     chain_output_oe_n,
   output logic        [dac_ctrl_pkg::DATA_W-1:0]   analog_output_code,
   output logic                                     analog_output_drive,
   output logic                                     analog_output_pd_1k,
   output logic                                     analog_output_pd_100k,
   output dac_ctrl_pkg::mode_t                      analog_output_mode
);
   import dac_ctrl_pkg::*;

   logic [SYNC_STAGES-1:0] frame_sync;
   logic [SYNC_STAGES-1:0] sclk_sync;
   logic [SYNC_STAGES-1:0] serial_input_line_sync;
   logic [SYNC_STAGES-1:0] clr_sync;
   logic                   frame_prev;
   logic                   sclk_prev;
   logic                   frame_n_s;
   logic                   sclk_s;
   logic                   serial_input_line_s;
   logic                   clr_n_s;
   logic                   sclk_fall;
   logic                   frame_rise;
   logic                   regs_clear;
   logic [WORD_BITS-1:0]   serial_command_word;
   logic [WORD_BITS-1:0]   cap_word;
   logic                   cap_valid;
   logic                   cap_ready;
   logic                   buf_valid;
   logic                   buf_ready;
   logic [WORD_BITS-1:0]   buf_word;
   logic                   dac_load;
   logic [DATA_W-1:0]      dac_code;
   mode_t                  dac_mode;
   logic                   chain_bit;

   // Two-stage samplers for every pin from outside the clock domain
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_sync <= '1;
         sclk_sync  <= '0;                     // Low reset value: never a false fall
         serial_input_line_sync  <= '0;
         clr_sync   <= '1;
      end else begin
         frame_sync <= {frame_sync[SYNC_STAGES-2:0], frame_select_n};
         sclk_sync  <= {sclk_sync[SYNC_STAGES-2:0], shift_clock};
         serial_input_line_sync  <= {serial_input_line_sync[SYNC_STAGES-2:0], serial_input_line};
         clr_sync   <= {clr_sync[SYNC_STAGES-2:0], async_zero_clear_n};
      end
   end

   assign frame_n_s = frame_sync[SYNC_STAGES-1];
   assign sclk_s    = sclk_sync[SYNC_STAGES-1];
   assign serial_input_line_s    = serial_input_line_sync[SYNC_STAGES-1];
   assign clr_n_s   = clr_sync[SYNC_STAGES-1];

   // Edge history of the sampled frame-select and shift clock
   always_ff @(posedge clk) begin
      if (reset) begin
         frame_prev <= 1'b1;
         sclk_prev  <= 1'b0;
      end else begin
         frame_prev <= frame_n_s;
         sclk_prev  <= sclk_s;
      end
   end

   // Shift only inside a frame, on a falling edge
   assign sclk_fall  = sclk_prev && !sclk_s && !frame_n_s;
   assign frame_rise = !frame_prev && frame_n_s;
   assign regs_clear = reset || !clr_n_s;

   // Input shift register, MSB first, no limit on edge count
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         serial_command_word <= WORD_RESET;
      end else if (sclk_fall) begin
         serial_command_word <= {serial_command_word[WORD_BITS-2:0], serial_input_line_s};
      end
   end

   // Chain bit follows the register end after each shift
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         chain_bit <= 1'b0;
      end else if (sclk_fall) begin
         chain_bit <= serial_command_word[WORD_BITS-2];
      end
   end

   // Chain pin driven only inside a frame
   assign chain_output_line = chain_bit;
   assign chain_output_oe_n = frame_n_s;

   // Frame end captures the current word, held until the buffer takes it
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         cap_valid <= 1'b0;
         cap_word  <= WORD_RESET;
      end else if (frame_rise) begin
         cap_valid <= 1'b1;
         cap_word  <= serial_command_word;
      end else if (cap_ready) begin
         cap_valid <= 1'b0;
      end
   end

   // Buffer drains only while the clear is released
   assign buf_ready = clr_n_s;

   word_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (BUF_DEPTH)
   ) u_word_fifo (
      .clk       (clk),
      .reset     (regs_clear),
      .in_valid  (cap_valid),
      .in_ready  (cap_ready),
      .in_data   (cap_word),
      .out_valid (buf_valid),
      .out_ready (buf_ready),
      .out_data  (buf_word)
   );

   assign dac_load = buf_valid && buf_ready;

   // Converter register: code and mode loaded together from one word
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         dac_code <= CODE_ZERO;
         dac_mode <= mode_normal;
      end else if (dac_load) begin
         dac_code <= buf_word[DATA_LSB +: DATA_W];
         dac_mode <= mode_t'(buf_word[MODE_MSB:MODE_LSB]);
      end
   end

   // Raw clear pin overrides the code without waiting for a clock
   assign analog_output_code = async_zero_clear_n ? dac_code : CODE_ZERO;
   assign analog_output_mode = async_zero_clear_n ? dac_mode : mode_normal;

   // Output stage control from the selected mode
   always_comb begin
      analog_output_drive   = 1'b0;
      analog_output_pd_1k   = 1'b0;
      analog_output_pd_100k = 1'b0;
      unique case (analog_output_mode)
         mode_normal:  analog_output_drive   = 1'b1;
         mode_pd_1k:   analog_output_pd_1k   = 1'b1;
         mode_pd_100k: analog_output_pd_100k = 1'b1;
         mode_pd_hiz:  analog_output_drive   = 1'b0;
      endcase
   end

   // Checks on the design's own outputs and internal registers
   a_clear_zero: assert property (@(posedge clk) disable iff (reset)
      !async_zero_clear_n |-> (analog_output_code == CODE_ZERO) && analog_output_drive)
      else $error("clear low but output not zero-scale");

   a_reset_zero: assert property (@(posedge clk)
      reset |=> (dac_code == CODE_ZERO) && (dac_mode == mode_normal) && !cap_valid)
      else $error("reset did not clear converter state");

   a_clear_regs: assert property (@(posedge clk) disable iff (reset)
      !clr_n_s |=> (serial_command_word == WORD_RESET) && (dac_code == CODE_ZERO))
      else $error("clear did not reset internal registers");

   a_shift_edge: assert property (@(posedge clk) disable iff (regs_clear)
      sclk_fall |=> serial_command_word == {$past(serial_command_word[WORD_BITS-2:0]), $past(serial_input_line_s)})
      else $error("falling edge did not shift serial bit");

   a_idle_hold: assert property (@(posedge clk) disable iff (regs_clear)
      frame_n_s && $past(frame_n_s) |=> $stable(serial_command_word))
      else $error("shift register moved outside a frame");

   a_frame_cap: assert property (@(posedge clk) disable iff (regs_clear)
      frame_rise |=> cap_valid && (cap_word == $past(serial_command_word)))
      else $error("frame end did not capture the word");

   a_load_path: assert property (@(posedge clk) disable iff (regs_clear)
      $changed(dac_code) |-> $past(dac_load))
      else $error("code changed without a latched word");

   a_cap_reach: assert property (@(posedge clk) disable iff (regs_clear)
      frame_rise && !buf_valid && !cap_valid ##1 clr_n_s[*3] |-> ##0 dac_load || $past(dac_load))
      else $error("captured word not loaded promptly");

   a_mode_1k: assert property (@(posedge clk) disable iff (reset)
      analog_output_mode == mode_pd_1k |-> analog_output_pd_1k && !analog_output_drive && !analog_output_pd_100k)
      else $error("1k power-down decoded wrongly");

   a_mode_normal: assert property (@(posedge clk) disable iff (reset)
      analog_output_mode == mode_normal |-> analog_output_drive && !analog_output_pd_1k && !analog_output_pd_100k)
      else $error("normal mode decoded wrongly");

   a_mode_100k: assert property (@(posedge clk) disable iff (reset)
      analog_output_mode == mode_pd_100k |-> analog_output_pd_100k && !analog_output_drive && !analog_output_pd_1k)
      else $error("100k power-down decoded wrongly");

   a_mode_hiz: assert property (@(posedge clk) disable iff (reset)
      analog_output_mode == mode_pd_hiz |-> !analog_output_drive && !analog_output_pd_1k && !analog_output_pd_100k)
      else $error("open power-down decoded wrongly");

   // Chain pin enable against the raw frame pin, two samples back
   a_chain_hiz: assert property (@(posedge clk) disable iff (reset)
      $past(frame_select_n, 2) |-> chain_output_oe_n)
      else $error("chain output driven outside a frame");

   a_chain_drive: assert property (@(posedge clk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && !$past(frame_select_n, 2) |-> !chain_output_oe_n)
      else $error("chain output released inside a frame");

   a_chain_hold: assert property (@(posedge clk) disable iff (regs_clear)
      !sclk_fall |=> $stable(chain_output_line))
      else $error("chain output moved without a shift");

   a_chain_bit: assert property (@(posedge clk) disable iff (regs_clear)
      sclk_fall |=> chain_output_line == $past(serial_command_word[WORD_BITS-2]))
      else $error("chain output not register end");

   a_pd_keep: assert property (@(posedge clk) disable iff (regs_clear)
      dac_load |=> dac_code == $past(buf_word[DATA_LSB +: DATA_W]))
      else $error("data bits dropped on load");

   a_mode_load: assert property (@(posedge clk) disable iff (regs_clear)
      dac_load |=> dac_mode == mode_t'($past(buf_word[MODE_MSB:MODE_LSB])))
      else $error("mode bits dropped on load");

   // Clear and reset side effects on the outputs and internal state
   a_clear_mode: assert property (@(posedge clk) disable iff (reset)
      !async_zero_clear_n |-> analog_output_mode == mode_normal)
      else $error("clear low but power-down still selected");

   a_clear_cap: assert property (@(posedge clk) disable iff (reset)
      !clr_n_s |=> !cap_valid && !buf_valid)
      else $error("clear left a captured word pending");

   a_clear_fresh: assert property (@(posedge clk) disable iff (reset)
      $rose(clr_n_s) |-> !cap_valid && !buf_valid)
      else $error("word from before the clear still pending");

   a_reset_chain: assert property (@(posedge clk)
      reset |=> !chain_output_line && chain_output_oe_n)
      else $error("reset did not park the chain output");

   // Main scenarios
   c_frame_load:  cover property (@(posedge clk) disable iff (reset) frame_rise ##[1:6] dac_load);
   c_powerdown:   cover property (@(posedge clk) disable iff (reset) dac_load ##1 dac_mode == mode_pd_hiz);
   c_chain_drive: cover property (@(posedge clk) disable iff (reset) !chain_output_oe_n && chain_output_line);
   c_clear:       cover property (@(posedge clk) disable iff (reset) dac_code != CODE_ZERO ##1 !async_zero_clear_n);
   c_pd_100k:     cover property (@(posedge clk) disable iff (reset) dac_load ##1 dac_mode == mode_pd_100k);
endmodule

// ---- dv/serial_host_model.sv ----
// Host serial controller model driving the converter's frame, clock and data pins
module serial_host_model (
   output logic      frame_select_n,
   output logic      shift_clock,
   output logic      serial_input_line,
   input  wire logic chain_output_line,
   input  wire logic chain_output_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam time HALF = 40ns;

   // Idle: frame high, link clock parked low
   initial begin
      frame_select_n    = 1'b1;
      shift_clock       = 1'b0;
      serial_input_line = 1'b0;
   end

   // One frame of n bits, MSB first; chain bit captured before each falling edge and once after the last
   task automatic send(input logic [63:0] bits, input int n, output logic [63:0] rx, output logic oe_mid);
      rx = '0;
      oe_mid = 1'b1;
      #10;
      frame_select_n = 1'b0;
      #HALF;
      for (int i = n - 1; i >= 0; i--) begin
         serial_input_line = bits[i];
         shift_clock = 1'b1;
         #HALF;
         rx = {rx[62:0], chain_output_line};
         oe_mid = chain_output_oe_n;
         shift_clock = 1'b0;
         #HALF;
      end
      #HALF;
      rx = {rx[62:0], chain_output_line};
      frame_select_n = 1'b1;
      serial_input_line = ~serial_input_line;   // Released line shows no stale level
      #HALF;
   endtask

   // Clock pulses with frame high, which the device must ignore
   task automatic idle_toggle(input int n);
      serial_input_line = 1'b1;
      for (int i = 0; i < n; i++) begin
         shift_clock = 1'b1;
         #HALF;
         shift_clock = 1'b0;
         #HALF;
      end
   endtask
endmodule

// ---- dv/test_serial_dac_control_interface.sv ----
// Self-checking bench of the serial converter control logic
module test_serial_dac_control_interface;
   timeunit 1ns;
   timeprecision 100ps;
   import dac_ctrl_pkg::*;

   logic        clk;
   logic        reset;
   logic        frame_select_n;
   logic        shift_clock;
   logic        serial_input_line;
   logic        async_zero_clear_n;
   logic        chain_output_line;
   logic        chain_output_oe_n;
   logic [11:0] analog_output_code;
   logic        analog_output_drive;
   logic        analog_output_pd_1k;
   logic        analog_output_pd_100k;
   mode_t       analog_output_mode;
   logic [63:0] rx;
   logic        oe_mid;
   int          err_count = 0;
   int          num_checks = 0;

   serial_dac_control_interface serial_dac_control_interface_i (
      .clk(clk), .reset(reset), .frame_select_n(frame_select_n), .shift_clock(shift_clock),
      .serial_input_line(serial_input_line), .async_zero_clear_n(async_zero_clear_n),
      .chain_output_line(chain_output_line), .chain_output_oe_n(chain_output_oe_n),
      .analog_output_code(analog_output_code), .analog_output_drive(analog_output_drive),
      .analog_output_pd_1k(analog_output_pd_1k), .analog_output_pd_100k(analog_output_pd_100k),
      .analog_output_mode(analog_output_mode));

   serial_host_model serial_host_model_i (
      .frame_select_n(frame_select_n), .shift_clock(shift_clock), .serial_input_line(serial_input_line),
      .chain_output_line(chain_output_line), .chain_output_oe_n(chain_output_oe_n));

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic stop_test();
      if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   // Code, mode and output-stage flags against one expected word
   task automatic check_out(input logic [15:0] e);
      chk("code", {4'h0, e[11:0]}, {4'h0, analog_output_code});
      chk("mode", {14'h0, e[13:12]}, {14'h0, analog_output_mode});
      chk("drive", {15'h0, e[13:12] == 2'b00}, {15'h0, analog_output_drive});
      chk("pd_1k", {15'h0, e[13:12] == 2'b01}, {15'h0, analog_output_pd_1k});
      chk("pd_100k", {15'h0, e[13:12] == 2'b10}, {15'h0, analog_output_pd_100k});
   endtask

   // Edges waited after send returns; the load lands about one edge after it
   localparam int LOAD_WAIT = 5;

   // Send a frame, wait a fixed time for the load, then judge the outputs
   task automatic frame(input logic [63:0] bits, input int n, input logic [15:0] e);
      @(posedge clk);
      #1;
      serial_host_model_i.send(bits, n, rx, oe_mid);
      repeat (LOAD_WAIT) @(posedge clk);
      #1;
      check_out(e);
      chk("oe_n idle", 16'h1, {15'h0, chain_output_oe_n});
   endtask

   task automatic pulse_reset();
      @(posedge clk);
      #1 reset = 1'b1;
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // Async clear: immediate zero, registers cleared, next frame end loads
   task automatic clear_scenario();
      @(posedge clk);
      #1 async_zero_clear_n = 1'b0;
      #1 check_out(16'h0000);
      repeat (5) @(posedge clk);
      #1 async_zero_clear_n = 1'b1;
      repeat (10) @(posedge clk);
      #1 check_out(16'h0000);
      frame(64'h5, 4, 16'h0005);
   endtask

   // Watchdog
   initial begin
      #500us;
      err_count++;
      stop_test();
   end

   // Power-on state: zero code, normal drive, chain pin released
   task automatic reset_scenario();
      #1 check_out(16'h0000);
      chk("oe_n reset", 16'h1, {15'h0, chain_output_oe_n});
   endtask

   // Plain words: leading bits ignored, full and zero scale codes
   task automatic word_scenario();
      frame(64'hC5A3, 16, 16'h05A3);
      frame(64'h0FFF, 16, 16'h0FFF);
      frame(64'h0000, 16, 16'h0000);
   endtask

   // Each power-down state with its data kept, then back to normal
   task automatic powerdown_scenario();
      logic [15:0] w;
      for (int m = 1; m < 4; m++) begin
         w = {2'b00, 2'(m), 12'h800 + 12'(m)};
         frame({48'h0, 2'b11, w[13:0]}, 16, w);
      end
      frame(64'h0ABC, 16, 16'h0ABC);
   endtask

   // Two chained words: last one latched, first one on the chain pin
   task automatic chain_scenario();
      frame(64'h9C36_1234, 32, 16'h1234);
      chk("chain data", 16'h9C36, rx[16:1]);
      chk("oe_n frame", 16'h0, {15'h0, oe_mid});
   endtask

   // Short frame, then clock pulses outside any frame
   task automatic short_idle_scenario();
      frame(64'h5A, 8, 16'h345A);
      serial_host_model_i.idle_toggle(16);
      frame(64'h0, 0, 16'h345A);
   endtask

   // Reset in mid-run: outputs back to zero, shift register emptied
   task automatic midrun_reset_scenario();
      frame(64'h0777, 16, 16'h0777);
      pulse_reset();
      #1 check_out(16'h0000);
      frame(64'hA, 4, 16'h000A);
   endtask

   initial begin
      reset = 1'b1;
      async_zero_clear_n = 1'b1;
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      reset_scenario();
      word_scenario();
      powerdown_scenario();
      chain_scenario();
      short_idle_scenario();
      clear_scenario();
      midrun_reset_scenario();
      stop_test();
   end
endmodule
